// File: src/cabinet_power_sequencer.sv
// Cabinet sequencer: power-on hold, regulator staging, reset and AC-low,
// power-fail handling, status forwarding and serial routing.
// Assumes one 20 MHz clock, an AXI4-Lite master and asynchronous pins.
`timescale 1ns/1ps
module cabinet_power_sequencer #(
    parameter int unsigned POR_CYCLES = cab_seq_pkg::POR_CYCLES,
    parameter int unsigned CNT_W      = 24
) (
    // Clock, reset and enable.
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic                     ce,
    // AXI4-Lite write channels.
    input  wire logic [3:0]               s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    // AXI4-Lite read channels.
    input  wire logic [3:0]               s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // Cabinet pins.
    input  wire cab_seq_pkg::pins_t       pins,
    // Regulator enables, active low: io port, front, rear slots.
    output logic [2:0]                    module_regulator_enable_n,
    // Open-collector reset request: value and enable.
    output logic                          system_reset_request_o,
    output logic                          system_reset_request_oe_n,
    // Power warnings and indicators.
    output logic                          ac_low_warning,
    output logic                          fault_indicator,
    output logic                          piu_reg_a_ok_o,
    output logic                          piu_reg_b_ok_o,
    output logic                          disk_pwr_ok_o,
    // Routed serial lines.
    output cab_seq_pkg::serial_out_t      serial
);

    cab_seq_pkg::pins_t     pin_s;       // Filtered pins.
    cab_seq_pkg::seq_state_t state_q;    // Sequencer state.
    logic [CNT_W-1:0]       cnt_q;       // Shared state timer.
    logic [2:0]             enable_q;    // Regulator enables, active high inside.
    logic                   reset_q;     // System reset driven.
    logic                   ac_low_warning_q;      // AC-low warning driven.
    logic [CNT_W-1:0]       pulse_q;     // Panel or software reset stretch.
    logic                   panel_q;     // Previous panel reset level.
    logic                   blower_q;    // Previous blower level.
    logic                   reg_good_q;  // Previous regulator-good level.
    logic [31:0]            ctrl_q;      // Control register.
    logic [cab_seq_pkg::EVT_W-1:0] evt_q; // Sticky events.
    logic                   sw_rst_pulse; // Software reset strobe.
    logic [cab_seq_pkg::EVT_W-1:0] evt_set; // Events this cycle.
    logic [cab_seq_pkg::EVT_W-1:0] evt_clr; // Clears this cycle.

    // Narrow an unsigned count to the timer width.
    function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
        cyc = CNT_W'(n);
    endfunction

    // All pins pass the three-stage filter.
    pin_sync #(
        .W ($bits(cab_seq_pkg::pins_t))
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .d       (pins),
        .q       (pin_s)
    );

    // Main sequencer. Battery state is no input, so nothing depends on it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Aux power just arrived: hold everything and start the power-on wait.
            state_q  <= cab_seq_pkg::ST_POR_WAIT;
            cnt_q    <= '0;
            enable_q <= 3'h0;
            reset_q  <= 1'b1;
            ac_low_warning_q   <= 1'b1;
        end else if (ce) begin
            unique case (state_q)
                cab_seq_pkg::ST_POR_WAIT: begin
                    // Hold reset for the full power-on time.
                    if (cnt_q >= cyc(POR_CYCLES - 1)) begin
                        state_q <= cab_seq_pkg::ST_KEY_OFF;
                        cnt_q   <= '0;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                cab_seq_pkg::ST_KEY_OFF: begin
                    // Wait for key, blower at speed and bulk power good.
                    enable_q <= 3'h0;
                    reset_q  <= 1'b1;
                    ac_low_warning_q   <= 1'b1;
                    cnt_q    <= '0;
                    if (pin_s.key_on && pin_s.blower_ok && pin_s.regulator_good) begin
                        state_q <= cab_seq_pkg::ST_POWER_UP;
                    end
                end
                cab_seq_pkg::ST_POWER_UP: begin
                    // Stage the three enables apart, then hold reset before release.
                    cnt_q       <= cnt_q + 1'b1;
                    enable_q[0] <= 1'b1;
                    if (cnt_q >= cyc(cab_seq_pkg::STAGE_CYCLES)) begin
                        enable_q[1] <= 1'b1;
                    end
                    if (cnt_q >= cyc(2 * cab_seq_pkg::STAGE_CYCLES)) begin
                        enable_q[2] <= 1'b1;
                    end
                    if (cnt_q >= cyc(2 * cab_seq_pkg::STAGE_CYCLES + cab_seq_pkg::UP_CYCLES)) begin
                        // Power is up: drop AC-low, release reset, modules self-test.
                        state_q <= cab_seq_pkg::ST_RUNNING;
                        ac_low_warning_q  <= 1'b0;
                        reset_q <= 1'b0;
                        cnt_q   <= '0;
                    end
                end
                cab_seq_pkg::ST_RUNNING: begin
                    // Loss of bulk power starts the orderly power-down.
                    if (!pin_s.regulator_good) begin
                        state_q <= cab_seq_pkg::ST_DOWN_RST;
                        reset_q <= 1'b1;
                        ac_low_warning_q  <= 1'b1;
                        cnt_q   <= '0;
                    end
                end
                cab_seq_pkg::ST_DOWN_RST: begin
                    // Reset and AC-low stand for the hold, then enables drop.
                    reset_q <= 1'b1;
                    ac_low_warning_q  <= 1'b1;
                    if (cnt_q >= cyc(cab_seq_pkg::DOWN_CYCLES - 1)) begin
                        enable_q <= 3'h0;
                        state_q  <= cab_seq_pkg::ST_AC_WAIT;
                        cnt_q    <= '0;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                cab_seq_pkg::ST_AC_WAIT: begin
                    // Idle until AC, bulk power and blower return, then power up again unaided.
                    enable_q <= 3'h0;
                    if (pin_s.ac_ok && pin_s.regulator_good && pin_s.blower_ok) begin
                        state_q <= cab_seq_pkg::ST_POWER_UP;
                        cnt_q   <= '0;
                    end
                end
                default: begin
                    // An illegal code recovers to the safe, key-off state.
                    state_q <= cab_seq_pkg::ST_KEY_OFF;
                end
            endcase
            // Keyswitch off overrides everything after the power-on wait.
            if (!pin_s.key_on && state_q != cab_seq_pkg::ST_POR_WAIT) begin
                state_q  <= cab_seq_pkg::ST_KEY_OFF;
                enable_q <= 3'h0;
                reset_q  <= 1'b1;
                ac_low_warning_q   <= 1'b1;
                cnt_q    <= '0;
            end
        end
    end

    // Panel edge or software strobe stretches a reset pulse.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_q <= '0;
            panel_q <= 1'b0;
        end else if (ce) begin
            panel_q <= pin_s.panel_reset;
            if ((pin_s.panel_reset && !panel_q) || sw_rst_pulse) begin
                pulse_q <= cyc(cab_seq_pkg::PANEL_CYCLES);
            end else if (pulse_q != '0) begin
                pulse_q <= pulse_q - 1'b1;
            end
        end
    end

    // Reset pin pulled low while its enable is low.
    assign system_reset_request_o    = 1'b0;
    assign system_reset_request_oe_n = ~(reset_q | (pulse_q != '0));
    assign ac_low_warning            = ac_low_warning_q;
    assign module_regulator_enable_n = ~enable_q;

    // Registered status copies and fault lamp.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_indicator <= 1'b1;
            piu_reg_a_ok_o  <= 1'b0;
            piu_reg_b_ok_o  <= 1'b0;
            disk_pwr_ok_o   <= 1'b0;
        end else if (ce) begin
            fault_indicator <= pin_s.module_fault;
            piu_reg_a_ok_o  <= pin_s.piu_reg_a_ok;
            piu_reg_b_ok_o  <= pin_s.piu_reg_b_ok;
            disk_pwr_ok_o   <= pin_s.disk_pwr_ok;
        end
    end

    // Serial routing; primary selection or expander mode swaps the regulator pair.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial <= '1;
        end else if (ce) begin
            if (pin_s.primary_selected || ctrl_q[cab_seq_pkg::CTRL_EXPANDER_BIT]) begin
                serial.exp_tx    <= pin_s.bp_reg_tx;
                serial.bp_reg_rx <= pin_s.exp_left_rx & pin_s.exp_right_rx;
                serial.reg_tx    <= 1'b1;
            end else begin
                serial.exp_tx    <= 1'b1;
                serial.bp_reg_rx <= pin_s.reg_rx;
                serial.reg_tx    <= pin_s.bp_reg_tx;
            end
            serial.bp_con_rx    <= pin_s.panel_con_rx;
            serial.panel_con_tx <= pin_s.bp_con_tx;
        end
    end

    // Event capture: set wins over a clear in the same cycle.
    always_comb begin
        evt_set = '0;
        evt_set[cab_seq_pkg::EVT_OVER_TEMP_BIT] = pin_s.over_temp;
        evt_set[cab_seq_pkg::EVT_BLOWER_BIT]    = blower_q && !pin_s.blower_ok;
        evt_set[cab_seq_pkg::EVT_REG_FAIL_BIT]  = reg_good_q && !pin_s.regulator_good;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_q      <= '0;
            blower_q   <= 1'b0;
            reg_good_q <= 1'b0;
        end else if (ce) begin
            blower_q   <= pin_s.blower_ok;
            reg_good_q <= pin_s.regulator_good;
            evt_q      <= (evt_q & ~evt_clr) | evt_set;
        end
    end

    // AXI write: address and data held apart, answered when both are in.
    logic        aw_have_q;  // Write address captured.
    logic        w_have_q;   // Write data captured.
    logic [3:0]  aw_q;       // Captured address.
    logic [31:0] wd_q;       // Captured data.
    logic [3:0]  ws_q;       // Captured strobes.
    logic        wr_go;      // Both halves present, no response pending.
    logic        wr_hit;     // Address maps to a writable register.

    assign s_axi_awready = ce && !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = ce && !w_have_q && !s_axi_bvalid;
    assign wr_go         = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_hit        = (aw_q == cab_seq_pkg::CTRL_OFS) || (aw_q == cab_seq_pkg::EVENT_OFS);
    assign sw_rst_pulse  = wr_go && aw_q == cab_seq_pkg::CTRL_OFS && ws_q[0]
                           && wd_q[cab_seq_pkg::CTRL_SW_RESET_BIT];
    assign evt_clr       = (wr_go && aw_q == cab_seq_pkg::EVENT_OFS && ws_q[0])
                           ? wd_q[cab_seq_pkg::EVT_W-1:0] : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            aw_q         <= 4'h0;
            wd_q         <= 32'h0000_0000;
            ws_q         <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= cab_seq_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_q      <= {s_axi_awaddr[3:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wd_q     <= s_axi_wdata;
                ws_q     <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? cab_seq_pkg::RESP_OKAY : cab_seq_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control register: only the expander bit is stored; the reset bit is a strobe.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= cab_seq_pkg::CTRL_RESET;
        end else if (ce && wr_go && aw_q == cab_seq_pkg::CTRL_OFS && ws_q[0]) begin
            ctrl_q[cab_seq_pkg::CTRL_EXPANDER_BIT] <= wd_q[cab_seq_pkg::CTRL_EXPANDER_BIT];
        end
    end

    // AXI read side: one cycle to answer, data held until taken.
    assign s_axi_arready = ce && !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= cab_seq_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= cab_seq_pkg::RESP_OKAY;
                unique case ({s_axi_araddr[3:2], 2'b00})
                    cab_seq_pkg::CTRL_OFS:   s_axi_rdata <= ctrl_q;
                    cab_seq_pkg::STATUS_OFS: s_axi_rdata <= {16'h0000, pin_s.over_temp,
                        pin_s.module_fault, pin_s.primary_selected, pin_s.ac_ok,
                        pin_s.regulator_good, pin_s.blower_ok, pin_s.key_on,
                        ac_low_warning_q, reset_q, enable_q, 1'b0, state_q};
                    cab_seq_pkg::EVENT_OFS:  s_axi_rdata <= {29'h0000_0000, evt_q};
                    default: begin
                        // Unmapped word reads zero with an error answer.
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= cab_seq_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// File: src/cab_seq_pkg.sv
// Shared constants and types for the cabinet power sequencer.
// Assumes one 20 MHz clock and a 32-bit AXI4-Lite port.
package cab_seq_pkg;

    // Clock rate and sequencer times.
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned POR_MS        = 400;
    localparam int unsigned UP_STAGE_US   = 10;
    localparam int unsigned UP_HOLD_US    = 100;
    localparam int unsigned DOWN_HOLD_US  = 50;
    localparam int unsigned PANEL_HOLD_US = 100;

    // Cycle counts; the clock is a whole number of MHz, so nothing overflows.
    localparam int unsigned POR_CYCLES   = (POR_MS * (CLK_HZ / 1000));
    localparam int unsigned STAGE_CYCLES = UP_STAGE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned UP_CYCLES    = UP_HOLD_US * (CLK_HZ / 1_000_000);
    localparam int unsigned DOWN_CYCLES  = DOWN_HOLD_US * (CLK_HZ / 1_000_000);
    localparam int unsigned PANEL_CYCLES = PANEL_HOLD_US * (CLK_HZ / 1_000_000);

    // Register byte offsets.
    localparam logic [3:0] CTRL_OFS   = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] EVENT_OFS  = 4'h8;

    // Control register fields and reset value.
    localparam int unsigned CTRL_EXPANDER_BIT = 0;
    localparam int unsigned CTRL_SW_RESET_BIT = 1;
    localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;

    // Event register fields.
    localparam int unsigned EVT_OVER_TEMP_BIT  = 0;
    localparam int unsigned EVT_BLOWER_BIT     = 1;
    localparam int unsigned EVT_REG_FAIL_BIT   = 2;
    localparam int unsigned EVT_W              = 3;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_POR_WAIT  = 3'h0,
        ST_KEY_OFF   = 3'h1,
        ST_POWER_UP  = 3'h2,
        ST_RUNNING   = 3'h3,
        ST_DOWN_RST  = 3'h4,
        ST_AC_WAIT   = 3'h5
    } seq_state_t;

    // Pin inputs, all from outside the clock domain.
    typedef struct packed {
        logic key_on;
        logic blower_ok;
        logic regulator_good;
        logic ac_ok;
        logic over_temp;
        logic panel_reset;
        logic primary_selected;
        logic module_fault;
        logic piu_reg_a_ok;
        logic piu_reg_b_ok;
        logic disk_pwr_ok;
        logic bp_reg_tx;
        logic reg_rx;
        logic exp_left_rx;
        logic exp_right_rx;
        logic bp_con_tx;
        logic panel_con_rx;
    } pins_t;

    // Serial line outputs after routing.
    typedef struct packed {
        logic bp_reg_rx;
        logic reg_tx;
        logic exp_tx;
        logic bp_con_rx;
        logic panel_con_tx;
    } serial_out_t;

endpackage

// File: src/pin_sync.sv
// Three-stage input synchroniser for a group of pin inputs.
// Assumes pins asynchronous to aclk; a change passes once stages two and three agree.
`timescale 1ns/1ps
module pin_sync #(
    parameter int unsigned W = 1
) (
    // Clock, reset and enable.
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    // Raw pins and filtered result.
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1_q;  // First stage, read only by the second.
    logic [W-1:0] s2_q;  // Second stage.
    logic [W-1:0] s3_q;  // Third stage.

    // Chain and filter; a bit whose stages disagree holds.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            q    <= '0;
        end else if (ce) begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q    <= (s2_q & ~(s2_q ^ s3_q)) | (q & (s2_q ^ s3_q));
        end
    end

endmodule

// File: bench/seq_checker.sv
// Port checker for the sequencer, bound after the module.
// Assumes pins hold steady a few cycles around each change.
`timescale 1ns/1ps
module seq_checker (
    // Clock and reset.
    input wire logic                     aclk,
    input wire logic                     aresetn,
    // Watched ports.
    input wire cab_seq_pkg::pins_t       pins,
    input wire logic [2:0]               module_regulator_enable_n,
    input wire logic                     system_reset_request_o,
    input wire logic                     system_reset_request_oe_n,
    input wire logic                     ac_low_warning,
    input wire logic                     fault_indicator,
    input wire logic                     piu_reg_a_ok_o,
    input wire cab_seq_pkg::serial_out_t serial
);
    // Short names; high rel means the reset line is let go.
    wire logic [2:0] en_n = module_regulator_enable_n;
    wire logic       rel  = system_reset_request_oe_n;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    enable_order_a: assert property (!en_n[2] |-> en_n[1:0] == 2'h0) else $error("enable order");
    reset_release_a: assert property (rel |-> en_n == 3'h0 && !ac_low_warning) else $error("early release");
    drive_low_a: assert property (system_reset_request_o == 1'h0) else $error("reset drive");
    key_off_a: assert property (!pins.key_on [*8] |-> en_n == 3'h7 && !rel) else $error("key off");
    start_cause_a: assert property (
        $fell(en_n[0]) |-> $past(pins.key_on, 6) && $past(pins.blower_ok, 6)) else $error("start cause");
    fail_reset_a: assert property (
        $fell(pins.regulator_good) && rel |-> ##[1:10] !rel && ac_low_warning) else $error("fail reset");
    down_order_a: assert property ($rose(en_n[0]) |-> !rel && ac_low_warning) else $error("down order");
    fault_track_a: assert property (
        $stable(pins.module_fault) [*8] |-> fault_indicator == pins.module_fault) else $error("fault");
    status_fwd_a: assert property (
        $stable(pins.piu_reg_a_ok) [*8] |-> piu_reg_a_ok_o == pins.piu_reg_a_ok) else $error("status");
    serial_route_a: assert property (
        (pins.primary_selected && $stable(pins.bp_reg_tx)) [*8] |-> serial.exp_tx == pins.bp_reg_tx && serial.reg_tx)
        else $error("route");
    // Main scenarios: release, start, panel press.
    cover property ($rose(rel));
    cover property ($fell(en_n[0]));
    cover property ($rose(pins.panel_reset));
endmodule
bind cabinet_power_sequencer seq_checker u_chk (.*);

// File: bench/bulk_reg_model.sv
// Bulk regulator model: mains presence, self-test; good drops at once on mains loss.
// Assumes mains_on changes just after a rising edge of aclk.
`timescale 1ns/1ps
module bulk_reg_model (
    // Clock and mains.
    input  wire logic aclk,
    input  wire logic mains_on,
    // Status to the sequencer.
    output logic      ac_ok,
    output logic      regulator_good
);
    logic       ok_q   = 1'h0;  // Mains seen last cycle.
    logic       good_q = 1'h0;  // Output good level.
    logic [4:0] test_q = 5'h00; // Self-test or holdover count.
    // Good after self-test and for one cycle as mains returns; on mains loss good drops at the next edge.
    always_ff @(posedge aclk) begin
        ok_q <= mains_on;
        test_q <= (mains_on != ok_q) ? 5'h00 : test_q + 5'(test_q != 5'h1F);
        good_q <= mains_on ? (test_q == 5'h1F) : (good_q && test_q < 5'h08);
    end
    assign ac_ok = ok_q;
    assign regulator_good = good_q;
endmodule

// File: bench/testbench.sv
// Self-checking bench for the sequencer and a bulk regulator model.
// Assumes a short power-on hold; other counts are the package's.
`timescale 1ns/1ps
module testbench;
    localparam int unsigned POR = 20; // Short hold keeps the run brief.
    logic                     aclk = 1'h0, aresetn = 1'h0, mains = 1'h0;
    logic [3:0]               awaddr = 4'h0, araddr = 4'h0, strb = 4'h0;
    logic [31:0]              wdata = 32'h0, rdata, d;
    logic                     awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic                     awready, wready, bvalid, arready, rvalid, ac_ok, rg, a_ok, b_ok, d_ok, fault, ac_low;
    logic                     rst_o, rst_oe_n;
    logic [1:0]               bresp, rresp;
    logic [2:0]               en_n;
    cab_seq_pkg::pins_t       p = 17'h0, pv;
    cab_seq_pkg::serial_out_t ser;
    int                       bad_count = 0, total_checks = 0;
    initial forever #25 aclk = ~aclk;
    // Regulator status from the model.
    always_comb begin
        pv = p;
        pv.ac_ok = ac_ok;
        pv.regulator_good = rg;
    end
    cabinet_power_sequencer #(.POR_CYCLES(POR)) u_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'h1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pins(pv), .module_regulator_enable_n(en_n), .system_reset_request_o(rst_o),
        .system_reset_request_oe_n(rst_oe_n), .ac_low_warning(ac_low), .fault_indicator(fault),
        .piu_reg_a_ok_o(a_ok), .piu_reg_b_ok_o(b_ok), .disk_pwr_ok_o(d_ok), .serial(ser));
    bulk_reg_model u_reg (.aclk(aclk), .mains_on(mains), .ac_ok(ac_ok), .regulator_good(rg));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Bounded wait on enables (sel 0) or reset release (sel 1).
    task automatic wait_for(input int sel, input logic [2:0] v, input int lim);
        for (int i = 0; i < lim && (sel ? {2'h0, rst_oe_n} : en_n) !== v; i++) @(posedge aclk);
        chk(32'(sel ? {2'h0, rst_oe_n} : en_n), 32'(v));
    endtask
    // Write: address and data together, each dropped when taken.
    task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er = cab_seq_pkg::RESP_OKAY);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        strb <= 4'h1;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        bready <= 1'h0;
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [3:0] a, input logic [1:0] er = cab_seq_pkg::RESP_OKAY);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        d = rdata;
        rready <= 1'h0;
        chk(32'(rresp), 32'(er));
    endtask
    task automatic st(input logic [2:0] s);
        rd(cab_seq_pkg::STATUS_OFS);
        chk(32'(d[2:0]), 32'(s));
    endtask
    // Reset levels, then the power-on hold.
    task automatic t_por();
        chk(32'({en_n, rst_oe_n, ac_low, ser}), 32'h3BF);
        aresetn <= 1'h1;
        st(cab_seq_pkg::ST_POR_WAIT);
        cyc(POR);
        st(cab_seq_pkg::ST_KEY_OFF);
    endtask
    // Key and mains without blower must not start; blower added starts the staged enables.
    task automatic t_up();
        p.key_on <= 1'h1;
        mains <= 1'h1;
        cyc(100);
        chk(32'(en_n), 32'h7);
        p.blower_ok <= 1'h1;
        wait_for(0, 3'h6, 20);
        cyc(100);
        chk(32'(en_n), 32'h6);
        wait_for(0, 3'h4, 150);
        wait_for(0, 3'h0, 250);
        chk(32'(rst_oe_n), 32'h0);
        wait_for(1, 3'h1, 2100);
        chk(32'(ac_low), 32'h0);
        st(cab_seq_pkg::ST_RUNNING);
    endtask
    task automatic t_panel();
        p.panel_reset <= 1'h1;
        cyc(10);
        p.panel_reset <= 1'h0;
        cyc(2);
        chk(32'(rst_oe_n), 32'h0);
        wait_for(1, 3'h1, 2100);
    endtask
    // Status forwarding, fault lamp, line routing by mode, events, unmapped place.
    task automatic t_route();
        // Status a, disk, primary, over-temperature, both expander rx and console rx go high.
        p <= p | 17'h0154D;
        cyc(10);
        chk(32'({a_ok, b_ok, d_ok, fault}), 32'hA);
        chk(32'(ser), 32'h1A);
        p.primary_selected <= 1'h0;
        rd(cab_seq_pkg::CTRL_OFS);
        chk(d, cab_seq_pkg::CTRL_RESET);
        cyc(3);
        chk(32'(ser), 32'h06);
        wr(cab_seq_pkg::CTRL_OFS, 32'h1);
        cyc(2);
        chk(32'(ser), 32'h1A);
        rd(cab_seq_pkg::EVENT_OFS);
        chk(32'(d[0]), 32'h1);
        p.over_temp <= 1'h0;
        cyc(8);
        wr(cab_seq_pkg::EVENT_OFS, 32'h7);
        rd(cab_seq_pkg::EVENT_OFS);
        chk(d, 32'h0);
        wr(4'hC, 32'h3, cab_seq_pkg::RESP_SLVERR);
        rd(4'hC, cab_seq_pkg::RESP_SLVERR);
        chk(d, 32'h0);
    endtask
    // Mains loss drops good at once, down reset, idle, restart, then key off.
    task automatic t_fail();
        mains <= 1'h0;
        wait_for(1, 3'h0, 30);
        chk(32'({en_n, ac_low}), 32'h1);
        wait_for(0, 3'h7, 1100);
        st(cab_seq_pkg::ST_AC_WAIT);
        rd(cab_seq_pkg::EVENT_OFS);
        chk(32'(d[2]), 32'h1);
        mains <= 1'h1;
        wait_for(0, 3'h6, 80);
        p.key_on <= 1'h0;
        wait_for(0, 3'h7, 20);
        chk(32'(rst_oe_n), 32'h0);
        st(cab_seq_pkg::ST_KEY_OFF);
    endtask
    initial begin
        cyc(20);
        t_por();
        t_up();
        t_panel();
        t_route();
        t_fail();
        end_of_test();
    end
    // A hang counts as a mismatch; the tests need well under half this span.
    initial begin
        #1_000_000;
        bad_count++;
        end_of_test();
    end
endmodule
